// *** adcc_defs.svh ***
// Register indices, field positions, reset values and timing counts
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH

// Word indices; the byte address is four times the index
`define ADCC_IDX_RUN        16'h1D26
`define ADCC_IDX_PGC        16'h1D27
`define ADCC_IDX_MFC        16'h1D28
`define ADCC_IDX_ETC        16'h1D29
`define ADCC_IDX_STAT       16'h1D2A
`define ADCC_IDX_PRE        16'h1D40
`define ADCC_IDX_STPT       16'h1D41
`define ADCC_IDX_UTH        16'h1D42
`define ADCC_IDX_LTH        16'h1D43
`define ADCC_IDX_RPT        16'h1D44
`define ADCC_IDX_RES        16'h1D45
`define ADCC_IDX_PREV       16'h1D46
`define ADCC_IDX_FILT       16'h1D47
`define ADCC_IDX_ERR        16'h1D48
`define ADCC_IDX_ACC        16'h1D49
`define ADCC_IDX_CNT        16'h1D4A

// Run control fields
`define ADCC_ON_BIT         7
`define ADCC_CONTINUOUS_BIT 6
`define ADCC_GO_BIT         0

// Precharge and guard control fields
`define ADCC_PRE_POL_BIT    7
`define ADCC_INV_PRE_BIT    6
`define ADCC_GUARD_POL_BIT  5
`define ADCC_CAP_ONLY_BIT   1
`define ADCC_DOUBLE_BIT     0

// Mode and filter control fields
`define ADCC_PREV_SRC_BIT   7
`define ADCC_SHIFT_LSB      4
`define ADCC_ACC_CLR_BIT    3
`define ADCC_MODE_LSB       0

// Error and threshold control fields
`define ADCC_ERR_SEL_LSB    4
`define ADCC_STOP_INT_BIT   3
`define ADCC_THR_MODE_LSB   0

// Implemented bits of the control registers
`define ADCC_RUN_MASK       8'hC1
`define ADCC_PGC_MASK       8'hE3
`define ADCC_ETC_MASK       8'h7F

// Reset values
`define ADCC_RST_CTL        8'h00
`define ADCC_RST_WORD       16'h0000

// Acquisition stage length
`define ADCC_CLK_NS         50
`define ADCC_ACQ_NS         1000
`define ADCC_ACQ_CYC ((`ADCC_ACQ_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)

`endif

// *** adcc_pkg.sv ***
// Shared types and arithmetic helper for the ADC control block
package adcc_pkg;

	typedef enum logic [2:0] {
		ADCC_MODE_BASIC = 3'h0,
		ADCC_MODE_ACCUM = 3'h1,
		ADCC_MODE_AVG   = 3'h2,
		ADCC_MODE_BURST = 3'h3,
		ADCC_MODE_LPF   = 3'h4
	} adcc_mode_e;

	typedef enum logic [2:0] {
		ADCC_ERR_RES_PREV  = 3'h0,
		ADCC_ERR_RES_STPT  = 3'h1,
		ADCC_ERR_RES_FILT  = 3'h2,
		ADCC_ERR_PREV_FILT = 3'h4,
		ADCC_ERR_FILT_STPT = 3'h5
	} adcc_err_e;

	typedef enum logic [2:0] {
		ADCC_THR_ALWAYS = 3'h0,
		ADCC_THR_ABOVE  = 3'h1,
		ADCC_THR_NABOVE = 3'h2,
		ADCC_THR_OUT    = 3'h3,
		ADCC_THR_IN     = 3'h4,
		ADCC_THR_NBELOW = 3'h5,
		ADCC_THR_BELOW  = 3'h6,
		ADCC_THR_NEVER  = 3'h7
	} adcc_thr_e;

	typedef enum logic [1:0] {
		ADCC_ST_IDLE = 2'h0,
		ADCC_ST_PRE  = 2'h1,
		ADCC_ST_ACQ  = 2'h2,
		ADCC_ST_CONV = 2'h3
	} adcc_stage_e;

	typedef logic signed [15:0] adcc_word_t;
	typedef logic signed [18:0] adcc_acc_t;

	function automatic adcc_acc_t adcc_shr(input adcc_acc_t v,
			input logic [2:0] n);
		return v >>> n;
	endfunction

endpackage

// *** adcc_seq.sv ***
// Conversion stage sequencer driving precharge, guard and convert lines
`timescale 1ns/1ps
`include "adcc_defs.svh"
module adcc_seq (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// Control
	input  wire logic        run,
	input  wire logic        double_sample_enable,
	input  wire logic        inverted_precharge_enable,
	input  wire logic        precharge_polarity,
	input  wire logic        guard_polarity,
	input  wire logic        capacitor_only_precharge,
	input  wire logic [7:0]  precharge_time,
	// Converter
	input  wire logic        adc_valid,
	input  wire logic [11:0] adc_data,
	// Events and status
	output logic             cycle_start,
	output logic             conv_done,
	output logic             pair_end,
	output logic [2:0]       stage,
	output logic [11:0]      conversion_result,
	// Pins
	output logic             pin_o,
	output logic             pin_oe,
	output logic             chold_precharge,
	output logic             chold_high,
	output logic             guard_output_a,
	output logic             guard_output_b,
	output logic             adc_convert
);
	typedef struct packed {
		adcc_pkg::adcc_stage_e st;
		logic [7:0]            cnt;
		logic                  second;
		logic                  start;
		logic                  done;
		logic                  pend;
		logic [11:0]           res;
		logic                  po;
		logic                  poe;
		logic                  pre;
		logic                  chi;
		logic                  ga;
		logic                  gb;
		logic                  conv;
	} adcc_seq_s;

	localparam logic [7:0] ACQ = 8'(`ADCC_ACQ_CYC);

	adcc_seq_s s;
	adcc_seq_s next_s;
	logic      inv;
	logic      pp;
	logic      gp;

	always_comb begin
		inv = double_sample_enable & inverted_precharge_enable & s.second;
		pp = precharge_polarity ^ inv;
		gp = guard_polarity ^ inv;
		next_s = s;
		next_s.start = 1'b0;
		next_s.done = 1'b0;
		next_s.pend = 1'b0;
		unique case (s.st)
			adcc_pkg::ADCC_ST_IDLE: begin
				if (!double_sample_enable)
					next_s.second = 1'b0;
				if (run) begin
					next_s.start = 1'b1;
					next_s.gb = gp;
					if (precharge_time != 8'h00) begin
						next_s.st = adcc_pkg::ADCC_ST_PRE;
						next_s.cnt = precharge_time;
						next_s.ga = gp;
						next_s.poe = ~capacitor_only_precharge;
						next_s.po = pp;
						next_s.pre = 1'b1;
						next_s.chi = ~pp;
					end else begin
						next_s.st = adcc_pkg::ADCC_ST_ACQ;
						next_s.cnt = ACQ;
						next_s.ga = ~gp;
					end
				end
			end
			adcc_pkg::ADCC_ST_PRE: begin
				if (s.cnt == 8'h01) begin
					next_s.st = adcc_pkg::ADCC_ST_ACQ;
					next_s.cnt = ACQ;
					next_s.poe = 1'b0;
					next_s.pre = 1'b0;
					next_s.ga = ~s.ga;
				end else
					next_s.cnt = s.cnt - 8'h01;
			end
			adcc_pkg::ADCC_ST_ACQ: begin
				if (s.cnt == 8'h01) begin
					next_s.st = adcc_pkg::ADCC_ST_CONV;
					next_s.conv = 1'b1;
				end else
					next_s.cnt = s.cnt - 8'h01;
			end
			adcc_pkg::ADCC_ST_CONV: begin
				if (adc_valid) begin
					next_s.st = adcc_pkg::ADCC_ST_IDLE;
					next_s.conv = 1'b0;
					next_s.res = adc_data;
					next_s.done = 1'b1;
					next_s.pend = ~double_sample_enable | s.second;
					next_s.second = double_sample_enable & ~s.second;
				end
			end
		endcase
		// Software stop aborts the cycle and releases the drivers
		if (!run && s.st != adcc_pkg::ADCC_ST_IDLE) begin
			next_s.st = adcc_pkg::ADCC_ST_IDLE;
			next_s.poe = 1'b0;
			next_s.pre = 1'b0;
			next_s.conv = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign cycle_start = s.start;
	assign conv_done = s.done;
	assign pair_end = s.pend;
	assign stage = {s.second, s.st};
	assign conversion_result = s.res;
	assign pin_o = s.po;
	assign pin_oe = s.poe;
	assign chold_precharge = s.pre;
	assign chold_high = s.chi;
	assign guard_output_a = s.ga;
	assign guard_output_b = s.gb;
	assign adc_convert = s.conv;
endmodule

// *** adcc_math.sv ***
// Computation unit: previous sample, accumulate, filter and error value
`timescale 1ns/1ps
module adcc_math (
	// Clock and reset
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	// Conversion events
	input  wire logic                 cycle_start,
	input  wire logic                 pair_end,
	input  wire logic [11:0]          conversion_result,
	// Configuration
	input  wire logic                 double_sample_enable,
	input  wire logic                 previous_sample_source,
	input  wire logic [2:0]           operating_mode_field,
	input  wire logic [2:0]           shift_field,
	input  wire logic [2:0]           error_calculation_field,
	input  wire logic [7:0]           repeat_sample_count,
	input  wire adcc_pkg::adcc_word_t setpoint,
	input  wire logic                 clear_request,
	// Results
	output adcc_pkg::adcc_word_t      previous_sample_register,
	output adcc_pkg::adcc_word_t      filter_result,
	output adcc_pkg::adcc_word_t      error_value,
	output logic [17:0]               accumulator,
	output logic [7:0]                sample_counter,
	output logic                      overflow_flag,
	output logic                      error_calculation_field_done,
	output logic                      clear_ack
);
	typedef struct packed {
		adcc_pkg::adcc_word_t prev;
		adcc_pkg::adcc_word_t filt;
		adcc_pkg::adcc_word_t err;
		logic signed [17:0]   acc;
		logic [7:0]           cnt;
		logic                 ovf;
		logic                 done;
		logic                 ack;
	} adcc_math_s;

	adcc_math_s           s;
	adcc_math_s           next_s;
	adcc_pkg::adcc_word_t x;
	adcc_pkg::adcc_word_t v;
	adcc_pkg::adcc_acc_t  sum;
	logic [7:0]           cnt1;
	logic [2:0]           sh;

	always_comb begin
		x = adcc_pkg::adcc_word_t'({4'h0, conversion_result});
		// Double sampling works on the pair difference
		v = double_sample_enable ? x - s.prev : x;
		sh = (operating_mode_field > adcc_pkg::ADCC_MODE_LPF ||
			operating_mode_field == adcc_pkg::ADCC_MODE_BASIC) ?
			3'h0 : shift_field;
		sum = '0;
		cnt1 = 8'h00;
		next_s = s;
		next_s.done = pair_end;
		next_s.ack = 1'b0;
		// Clear goes first so an overflow in the same cycle still sets
		if (clear_request && !s.ack) begin
			next_s.acc = '0;
			next_s.cnt = 8'h00;
			next_s.ovf = 1'b0;
			next_s.ack = 1'b1;
		end
		if (cycle_start)
			next_s.prev = previous_sample_source ? s.filt : x;
		if (pair_end) begin
			sum = adcc_pkg::adcc_acc_t'(next_s.acc) +
				adcc_pkg::adcc_acc_t'(v);
			cnt1 = next_s.cnt + 8'h01;
			unique case (operating_mode_field)
				adcc_pkg::ADCC_MODE_ACCUM: begin
					next_s.acc = sum[17:0];
					next_s.cnt = cnt1;
					next_s.ovf = next_s.ovf | (sum[18] ^ sum[17]);
					next_s.filt = adcc_pkg::adcc_word_t'(
						adcc_pkg::adcc_shr(sum, sh));
				end
				adcc_pkg::ADCC_MODE_AVG, adcc_pkg::ADCC_MODE_BURST: begin
					next_s.ovf = next_s.ovf | (sum[18] ^ sum[17]);
					if (cnt1 >= repeat_sample_count) begin
						next_s.filt = adcc_pkg::adcc_word_t'(
							adcc_pkg::adcc_shr(sum, sh));
						next_s.acc = '0;
						next_s.cnt = 8'h00;
					end else begin
						next_s.acc = sum[17:0];
						next_s.cnt = cnt1;
					end
				end
				adcc_pkg::ADCC_MODE_LPF: begin
					sum = adcc_pkg::adcc_acc_t'(v) -
						adcc_pkg::adcc_acc_t'(s.filt);
					sum = adcc_pkg::adcc_acc_t'(s.filt) +
						adcc_pkg::adcc_shr(sum, sh);
					next_s.filt = adcc_pkg::adcc_word_t'(sum);
				end
				default: ;
			endcase
			unique case (error_calculation_field)
				adcc_pkg::ADCC_ERR_RES_PREV: next_s.err = x - s.prev;
				adcc_pkg::ADCC_ERR_RES_STPT: next_s.err = v - setpoint;
				adcc_pkg::ADCC_ERR_RES_FILT: next_s.err = v - next_s.filt;
				adcc_pkg::ADCC_ERR_PREV_FILT: next_s.err = s.prev - next_s.filt;
				adcc_pkg::ADCC_ERR_FILT_STPT: next_s.err = next_s.filt - setpoint;
				default: ;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign previous_sample_register = s.prev;
	assign filter_result = s.filt;
	assign error_value = s.err;
	assign accumulator = s.acc;
	assign sample_counter = s.cnt;
	assign overflow_flag = s.ovf;
	assign error_calculation_field_done = s.done;
	assign clear_ack = s.ack;
endmodule

// *** adcc_top.sv ***
// ADC precharge, guard and computation control with AHB-Lite registers
`timescale 1ns/1ps
`include "adcc_defs.svh"
//
// Contract
// - Precharge polarity sets pin and capacitor opposite
// - Inverted precharge flips second cycle levels
// - Otherwise both cycles use configured polarities
// - Guard polarity sets guard start level
// - Capacitor-only bit skips external pin precharge
// - Double sampling computes after every second conversion
// - Conversion start copies filter or result
// - Filter time constant is two to shift
// - Accumulating modes right-shift by shift field
// - Shift ignored in basic mode or modes above low-pass
// - Clear command empties accumulator, counter, overflow
// - Mode field selects five operating modes
// - Error field selects error value source
// - Double sampling uses pair difference
// - Error only after second sample when paired
// - Stop-on-interrupt clears start on threshold
// - Threshold mode selects interrupt comparison
// - Acquisition toggles guard A, holds B
module adcc_top (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// Converter core
	input  wire logic        adc_valid,
	input  wire logic [11:0] adc_data,
	output logic             adc_convert,
	// Precharge and guard pins
	output logic             pin_o,
	output logic             pin_oe,
	output logic             chold_precharge,
	output logic             chold_high,
	output logic             guard_output_a,
	output logic             guard_output_b,
	// Threshold event
	output logic             threshold_event
);
	typedef struct packed {
		logic [7:0]           run;
		logic [7:0]           pgc;
		logic [7:0]           mfc;
		logic [7:0]           etc;
		logic [7:0]           pre;
		logic [7:0]           rpt;
		adcc_pkg::adcc_word_t stpt;
		adcc_pkg::adcc_word_t uth;
		adcc_pkg::adcc_word_t lth;
		logic                 uthr;
		logic                 lthr;
		logic                 thr;
		logic                 pend;
		logic                 wr;
		logic [15:0]          idx;
		logic [31:0]          rdata;
		logic                 rdy;
		logic                 resp;
	} adcc_top_s;

	adcc_top_s s;
	adcc_top_s next_s;

	// Control fields
	logic       adc_on;
	logic       continuous_operation;
	logic       go;
	logic       precharge_polarity;
	logic       inverted_precharge_enable;
	logic       guard_polarity;
	logic       capacitor_only_precharge;
	logic       double_sample_enable;
	logic       previous_sample_source;
	logic [2:0] shift_field;
	logic       accumulator_clear_command;
	logic [2:0] operating_mode_field;
	logic [2:0] error_calculation_field;
	logic       stop_on_interrupt;
	logic [2:0] threshold_mode_field;

	// Sequencer and computation results
	logic                 run;
	logic                 cycle_start;
	logic                 conv_done;
	logic                 pair_end;
	logic [2:0]           stage;
	logic [11:0]          conversion_result;
	adcc_pkg::adcc_word_t previous_sample_register;
	adcc_pkg::adcc_word_t filter_result;
	adcc_pkg::adcc_word_t error_value;
	logic [17:0]          accumulator;
	logic [7:0]           sample_counter;
	logic                 overflow_flag;
	logic                 error_calculation_field_done;
	logic                 clear_ack;
	logic                 hit;
	logic                 above;
	logic                 below;
	logic [15:0]          a_idx;
	logic [31:0]          rd;

	assign adc_on = s.run[`ADCC_ON_BIT];
	assign continuous_operation = s.run[`ADCC_CONTINUOUS_BIT];
	assign go = s.run[`ADCC_GO_BIT];
	assign precharge_polarity = s.pgc[`ADCC_PRE_POL_BIT];
	assign inverted_precharge_enable = s.pgc[`ADCC_INV_PRE_BIT];
	assign guard_polarity = s.pgc[`ADCC_GUARD_POL_BIT];
	assign capacitor_only_precharge = s.pgc[`ADCC_CAP_ONLY_BIT];
	assign double_sample_enable = s.pgc[`ADCC_DOUBLE_BIT];
	assign previous_sample_source = s.mfc[`ADCC_PREV_SRC_BIT];
	assign shift_field = s.mfc[`ADCC_SHIFT_LSB +: 3];
	assign accumulator_clear_command = s.mfc[`ADCC_ACC_CLR_BIT];
	assign operating_mode_field = s.mfc[`ADCC_MODE_LSB +: 3];
	assign error_calculation_field = s.etc[`ADCC_ERR_SEL_LSB +: 3];
	assign stop_on_interrupt = s.etc[`ADCC_STOP_INT_BIT];
	assign threshold_mode_field = s.etc[`ADCC_THR_MODE_LSB +: 3];

	// No new cycle while a finished conversion is still being judged
	assign run = go & adc_on & ~conv_done & ~s.pend;

	adcc_seq u_seq (
		.hclk                      (hclk),
		.hresetn                   (hresetn),
		.run                       (run),
		.double_sample_enable      (double_sample_enable),
		.inverted_precharge_enable (inverted_precharge_enable),
		.precharge_polarity        (precharge_polarity),
		.guard_polarity            (guard_polarity),
		.capacitor_only_precharge  (capacitor_only_precharge),
		.precharge_time            (s.pre),
		.adc_valid                 (adc_valid),
		.adc_data                  (adc_data),
		.cycle_start               (cycle_start),
		.conv_done                 (conv_done),
		.pair_end                  (pair_end),
		.stage                     (stage),
		.conversion_result         (conversion_result),
		.pin_o                     (pin_o),
		.pin_oe                    (pin_oe),
		.chold_precharge           (chold_precharge),
		.chold_high                (chold_high),
		.guard_output_a            (guard_output_a),
		.guard_output_b            (guard_output_b),
		.adc_convert               (adc_convert)
	);

	adcc_math u_math (
		.hclk                     (hclk),
		.hresetn                  (hresetn),
		.cycle_start              (cycle_start),
		.pair_end                 (pair_end),
		.conversion_result        (conversion_result),
		.double_sample_enable     (double_sample_enable),
		.previous_sample_source   (previous_sample_source),
		.operating_mode_field     (operating_mode_field),
		.shift_field              (shift_field),
		.error_calculation_field  (error_calculation_field),
		.repeat_sample_count      (s.rpt),
		.setpoint                 (s.stpt),
		.clear_request            (accumulator_clear_command),
		.previous_sample_register (previous_sample_register),
		.filter_result            (filter_result),
		.error_value              (error_value),
		.accumulator              (accumulator),
		.sample_counter           (sample_counter),
		.overflow_flag            (overflow_flag),
		.error_calculation_field_done                (error_calculation_field_done),
		.clear_ack                (clear_ack)
	);

	// Threshold test on the freshly computed error value
	always_comb begin
		above = error_value > s.uth;
		below = error_value < s.lth;
		hit = 1'b0;
		unique case (threshold_mode_field)
			adcc_pkg::ADCC_THR_ALWAYS: hit = 1'b1;
			adcc_pkg::ADCC_THR_ABOVE:  hit = above;
			adcc_pkg::ADCC_THR_NABOVE: hit = ~above;
			adcc_pkg::ADCC_THR_OUT:    hit = below | above;
			adcc_pkg::ADCC_THR_IN:
				hit = (error_value > s.lth) & (error_value < s.uth);
			adcc_pkg::ADCC_THR_NBELOW: hit = ~below;
			adcc_pkg::ADCC_THR_BELOW:  hit = below;
			adcc_pkg::ADCC_THR_NEVER:  hit = 1'b0;
		endcase
	end

	// Word index of an aligned access inside the low address window
	assign a_idx = (haddr[31:18] == 14'h0000 && haddr[1:0] == 2'h0) ?
		haddr[17:2] : 16'h0000;

	always_comb begin
		rd = 32'h0000_0000;
		next_s = s;
		next_s.pend = conv_done;
		next_s.thr = 1'b0;
		// Hardware clears first so a same-cycle software set wins
		if (s.pend) begin
			if (!continuous_operation)
				next_s.run[`ADCC_GO_BIT] = 1'b0;
			else if (stop_on_interrupt && error_calculation_field_done && hit)
				next_s.run[`ADCC_GO_BIT] = 1'b0;
		end
		if (error_calculation_field_done) begin
			next_s.uthr = above;
			next_s.lthr = below;
			next_s.thr = hit;
		end
		if (clear_ack)
			next_s.mfc[`ADCC_ACC_CLR_BIT] = 1'b0;
		// Data phase write
		if (s.wr) begin
			unique case (s.idx)
				`ADCC_IDX_RUN: next_s.run = hwdata[7:0] & `ADCC_RUN_MASK;
				`ADCC_IDX_PGC: next_s.pgc = hwdata[7:0] & `ADCC_PGC_MASK;
				`ADCC_IDX_MFC: next_s.mfc = hwdata[7:0];
				`ADCC_IDX_ETC: next_s.etc = hwdata[7:0] & `ADCC_ETC_MASK;
				`ADCC_IDX_PRE: next_s.pre = hwdata[7:0];
				`ADCC_IDX_STPT: next_s.stpt = hwdata[15:0];
				`ADCC_IDX_UTH: next_s.uth = hwdata[15:0];
				`ADCC_IDX_LTH: next_s.lth = hwdata[15:0];
				`ADCC_IDX_RPT: next_s.rpt = hwdata[7:0];
				default: ;
			endcase
		end
		// Configuration reads reflect this cycle's updates; result reads return the held value
		unique case (a_idx)
			`ADCC_IDX_RUN: rd[7:0] = next_s.run;
			`ADCC_IDX_PGC: rd[7:0] = next_s.pgc;
			`ADCC_IDX_MFC: rd[7:0] = next_s.mfc;
			`ADCC_IDX_ETC: rd[7:0] = next_s.etc;
			`ADCC_IDX_STAT:
				rd[7:0] = {overflow_flag, next_s.uthr, next_s.lthr, 2'h0, stage};
			`ADCC_IDX_PRE: rd[7:0] = next_s.pre;
			`ADCC_IDX_STPT: rd[15:0] = next_s.stpt;
			`ADCC_IDX_UTH: rd[15:0] = next_s.uth;
			`ADCC_IDX_LTH: rd[15:0] = next_s.lth;
			`ADCC_IDX_RPT: rd[7:0] = next_s.rpt;
			`ADCC_IDX_RES: rd[11:0] = conversion_result;
			`ADCC_IDX_PREV: rd[15:0] = previous_sample_register;
			`ADCC_IDX_FILT: rd[15:0] = filter_result;
			`ADCC_IDX_ERR: rd[15:0] = error_value;
			`ADCC_IDX_ACC: rd[17:0] = accumulator;
			`ADCC_IDX_CNT: rd[7:0] = sample_counter;
			default: ;
		endcase
		// Address phase
		next_s.wr = 1'b0;
		next_s.rdy = 1'b1;
		next_s.resp = 1'b0;
		if (hready && hsel && htrans[1]) begin
			next_s.idx = a_idx;
			next_s.wr = hwrite;
			next_s.rdata = hwrite ? 32'h0000_0000 : rd;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.run <= `ADCC_RST_CTL;
			s.pgc <= `ADCC_RST_CTL;
			s.mfc <= `ADCC_RST_CTL;
			s.etc <= `ADCC_RST_CTL;
			s.stpt <= `ADCC_RST_WORD;
			s.rdy <= 1'b1;
		end else
			s <= next_s;
	end

	assign hreadyout = s.rdy;
	assign hrdata = s.rdata;
	assign hresp = s.resp;
	assign threshold_event = s.thr;
endmodule

// *** adcc_properties.sv ***
// Checker of pin, guard, event and bus relations at the block ports
`timescale 1ns/1ps
module adcc_properties (
	// Clock, reset and watched outputs
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic adc_convert,
	input wire logic pin_o,
	input wire logic pin_oe,
	input wire logic chold_precharge,
	input wire logic chold_high,
	input wire logic guard_output_a,
	input wire logic guard_output_b,
	input wire logic threshold_event
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_pin_cap_opposite: assert property (
		pin_oe |-> pin_o != chold_high) else $error("pin equals capacitor");
	a_pin_in_precharge: assert property (
		pin_oe |-> chold_precharge) else $error("pin driven outside precharge");
	a_guards_equal: assert property (
		chold_precharge |-> guard_output_a == guard_output_b)
		else $error("guards differ in precharge");
	a_guard_a_toggle: assert property (
		$fell(chold_precharge) |-> guard_output_a != $past(guard_output_a)
		&& $stable(guard_output_b)) else $error("guard toggle wrong");
	a_acq_length: assert property (
		$fell(chold_precharge) |-> !adc_convert[*8] ##[11:13] $rose(adc_convert))
		else $error("acquisition length wrong");
	a_convert_released: assert property (
		adc_convert |-> !pin_oe && !chold_precharge)
		else $error("drivers on in conversion");
	a_event_after_conv: assert property (
		threshold_event |-> !adc_convert && ($past(adc_convert, 1)
		|| $past(adc_convert, 2) || $past(adc_convert, 3)))
		else $error("event without conversion");
	a_event_pulse: assert property (
		threshold_event |=> !threshold_event) else $error("event too long");
	a_bus_okay: assert property (
		hreadyout && !hresp) else $error("bus not ready or error");
endmodule
bind adcc_top adcc_properties i_props (.hclk, .hresetn, .hreadyout, .hresp,
	.adc_convert, .pin_o, .pin_oe, .chold_precharge, .chold_high,
	.guard_output_a, .guard_output_b, .threshold_event);

// *** testbench.sv ***
// Self-checking bench for the ADC control block
`timescale 1ns/1ps
`include "adcc_defs.svh"
`define CHK(n,e,a) begin checked++; if ((a) !== (e)) begin n_errors++; \
$display("[FAIL] %s exp %h got %h", n, e, a); end end
module testbench;
	logic        hclk = 0, hresetn = 0, hwrite = 0, adc_valid = 0, hready;
	logic [1:0]  htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, rd;
	logic [11:0] adc_data = 0, last, p;
	logic        hreadyout, hresp, adc_convert, pin_o, pin_oe, cp, ch, ga, gb, te;
	logic [7:0]  cfg;
	logic [15:0] sp, f;
	int          n_errors = 0, checked = 0, n_ev = 0, e0, i, k;
	assign hready = hreadyout;
	always #25 hclk = ~hclk;
	// Converter answers after a random delay
	always @(posedge hclk) begin
		adc_valid <= adc_convert & ~adc_valid & 1'($urandom % 2);
		adc_data <= 12'($urandom);
		if (adc_valid && adc_convert) last <= adc_data;
		if (te === 1'b1) n_ev <= n_ev + 1;
	end
	adcc_top i_dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready, .hreadyout, .hrdata(rd), .hresp,
		.adc_valid, .adc_data, .adc_convert, .pin_o, .pin_oe,
		.chold_precharge(cp), .chold_high(ch), .guard_output_a(ga),
		.guard_output_b(gb), .threshold_event(te));
	task finish_test;
		$display("checked %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task tmo(input int n);
		if (n >= 200) begin
			n_errors++;
			finish_test();
		end
	endtask
	task bus(input logic w, input logic [15:0] x, input logic [31:0] d);
		haddr <= {14'h0, x, 2'h0};
		hwrite <= w;
		htrans <= 2'h2;
		for (k = 0; k < 200; k++) begin @(posedge hclk); if (hready === 1'b1) break; end
		tmo(k);
		htrans <= 2'h0;
		hwdata <= d;
		for (k = 0; k < 200; k++) begin @(posedge hclk); if (hready === 1'b1) break; end
		tmo(k);
	endtask
	task wr(input logic [15:0] x, input logic [31:0] d);
		bus(1'b1, x, d);
	endtask
	task chk(input string n, input logic [15:0] x, input logic [31:0] e);
		bus(1'b0, x, 32'h0);
		`CHK(n, e, rd)
	endtask
	// Waits for precharge (s = 0) or event (s = 1) to reach v
	task wlv(input logic v, input int s);
		for (k = 0; k < 200; k++) begin
			@(posedge hclk);
			#1;
			if ((s ? te : cp) === v) break;
		end
		tmo(k);
	endtask
	task run_pre(input logic [7:0] c, input logic inv);
		wlv(1'b1, 0);
		`CHK("pin_oe", ~c[1], pin_oe)
		if (!c[1]) `CHK("pin_o", c[7] ^ inv, pin_o)
		`CHK("chold", ~(c[7] ^ inv), ch)
		`CHK("guard", {2{c[5] ^ inv}}, {ga, gb})
	endtask
	// Low-pass step: old value plus shifted difference, wrapped to 16 bits
	function automatic logic [15:0] lpf(input logic [15:0] o,
			input logic [11:0] r, input logic [2:0] n);
		logic signed [18:0] d;
		d = $signed({7'h0, r}) - $signed({{3{o[15]}}, o});
		return o + 16'(d >>> n);
	endfunction
	initial begin
		k = $urandom(44);
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("pgc", `ADCC_IDX_PGC, 32'h0);
		chk("mfc", `ADCC_IDX_MFC, 32'h0);
		chk("etc", `ADCC_IDX_ETC, 32'h0);
		wr(`ADCC_IDX_PGC, 32'hFF);
		chk("pgc mask", `ADCC_IDX_PGC, 32'hE3);
		wr(`ADCC_IDX_ETC, 32'hFF);
		chk("etc mask", `ADCC_IDX_ETC, 32'h7F);
		chk("unmapped", 16'h0100, 32'h0);
		$display("test registers done");
		// Stop after each computed conversion or pair
		wr(`ADCC_IDX_PRE, 32'h3);
		wr(`ADCC_IDX_ETC, 32'h08);
		for (i = 0; i < 12; i++) begin
			cfg = 8'($urandom) & 8'hE3;
			e0 = n_ev;
			wr(`ADCC_IDX_PGC, {24'h0, cfg});
			wr(`ADCC_IDX_RUN, 32'hC1);
			run_pre(cfg, 1'b0);
			if (cfg[0]) begin
				wlv(1'b0, 0);
				run_pre(cfg, cfg[6]);
				`CHK("pair event", e0, n_ev)
			end
			wlv(1'b1, 1);
			repeat (4) @(posedge hclk);
		end
		$display("test precharge done");
		wr(`ADCC_IDX_PGC, 32'h0);
		sp = 16'($urandom % 4096);
		p = last;
		wr(`ADCC_IDX_STPT, {16'h0, sp});
		wr(`ADCC_IDX_ETC, 32'h18);
		wr(`ADCC_IDX_RPT, 32'h2);
		wr(`ADCC_IDX_MFC, 32'h11);
		wr(`ADCC_IDX_RUN, 32'hC1);
		wlv(1'b1, 1);
		@(posedge hclk);
		chk("error", `ADCC_IDX_ERR, {16'h0, {4'h0, last} - sp});
		chk("prev", `ADCC_IDX_PREV, {20'h0, p});
		f = 16'({4'h0, last} >> 1);
		chk("acc", `ADCC_IDX_ACC, {20'h0, last});
		chk("cnt", `ADCC_IDX_CNT, 32'h1);
		chk("filter", `ADCC_IDX_FILT, {16'h0, f});
		wr(`ADCC_IDX_MFC, 32'h19);
		// Read data is taken at the address edge, so let the clear land
		@(posedge hclk);
		chk("acc clr", `ADCC_IDX_ACC, 32'h0);
		chk("cnt clr", `ADCC_IDX_CNT, 32'h0);
		chk("clr bit", `ADCC_IDX_MFC, 32'h11);
		wr(`ADCC_IDX_ETC, 32'h28);
		wr(`ADCC_IDX_MFC, 32'h14);
		wr(`ADCC_IDX_RUN, 32'hC1);
		wlv(1'b1, 1);
		@(posedge hclk);
		f = lpf(f, last, 3'h1);
		chk("lpf", `ADCC_IDX_FILT, {16'h0, f});
		chk("err2", `ADCC_IDX_ERR, {16'h0, {4'h0, last} - f});
		$display("test computation done");
		finish_test();
	end
endmodule
